// file: hdl/pwm_ppg_map.vh
// Register map, field positions and reset values of the 16-bit pulse timer
`ifndef PWM_PPG_MAP_VH
`define PWM_PPG_MAP_VH

// Register byte offsets (word aligned)
`define DUTY_LOW_OFS 8'h00
`define DUTY_HIGH_OFS 8'h04
`define PERIOD_LOW_OFS 8'h08
`define PERIOD_HIGH_OFS 8'h0C
`define LOWER_CTRL_OFS 8'h10
`define UPPER_CTRL_OFS 8'h14
`define STATUS_OFS 8'h18

// upper_timer_control fields
`define UCTRL_LEVEL_BIT 7
`define UCTRL_START_BIT 3
`define UCTRL_MODE_HI 2
`define UCTRL_MODE_LO 0
`define MODE_PWM16 3'h6
`define MODE_PPG16 3'h7

// lower_timer_control fields
`define LCTRL_HALVE_BIT 7
`define LCTRL_CLK_HI 6
`define LCTRL_CLK_LO 4
`define CLK_DIV2_11 3'h0
`define CLK_DIV2_7 3'h1
`define CLK_DIV2_5 3'h2
`define CLK_DIV2_3 3'h3
`define CLK_EXTERNAL 3'h7

// Prescaler tap exponents and prescaler width
`define TAP_EXP_11 4'hB
`define TAP_EXP_7 4'h7
`define TAP_EXP_5 4'h5
`define TAP_EXP_3 4'h3
`define PRESC_WIDTH 13

// Status word fields
`define STAT_CNT_LO 0
`define STAT_FF_BIT 16
`define STAT_RUN_BIT 17

// Reset values and counter maximum
`define CTRL_RESET 8'h00
`define CMP_RESET 16'h0000
`define CNT_MAX 16'hFFFF

// AHB-Lite encodings
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD 3'h2

`endif

// file: hdl/pwm_ppg_timer.v
// 16-bit cascaded PWM / programmable pulse timer with an AHB-Lite slave
//
// How it works
// R01: Two 8-bit counters chain into one 16-bit counter
// R02: Counter steps on prescaler tick or external edge
// R03: PWM: duty match toggles flip-flop, counting continues
// R04: PWM: overflow toggles, clears counter, raises interrupt
// R05: External input levels last two machine cycles
// R06: Flip-flop loads initial level; reset clears it
// R07: Output pin is complement of flip-flop
// R08: PWM duty write while running waits for interrupt
// R09: PWM duty write while stopped applies at once
// R10: Duty reads return active value during PWM
// R11: Software writes low byte before high byte
// R12: Software updates duty right after the interrupt; the bench writes it just after start
// R13: Stopping holds output level until level rewritten
// R14: Software stops first, then changes level bit
// R15: Clear bit 3 stops; clear bit 7 drives pin high
// R16: Software stops counter before deep sleep
// R17: PPG: duty match toggles; period match toggles, clears
// R18: PPG compare registers unbuffered, written only when stopped
// R19: Software sets the port latch before pulse output; the bench takes it as already set
// R20: Low byte held, whole value committed on high byte
// R21: Clock field picks prescaler tap or external pin
// R22: Start clears counter; stop halts, keeps output
`include "pwm_ppg_map.vh"

module pwm_ppg_timer (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // Timer pins
  input wire external_count_input,
  output reg inverted_pwm_pin,
  output reg inverted_ppg_pin,
  output reg period_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave state

  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  wire addr_phase;
  wire wr_take;
  wire rd_take;
  wire [7:0] wr_byte;

  assign addr_phase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  // Only whole-word writes are taken; other sizes are dropped
  assign wr_take = addr_phase & hwrite & (hsize == `HSIZE_WORD);
  assign rd_take = addr_phase & ~hwrite;
  assign wr_byte = hwdata[7:0];

  // Reads get one wait state so a write just before is always visible
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_ff <= wr_take;
      if (wr_take) begin
        wr_addr_ff <= haddr;
      end
      hreadyout <= ~rd_take;
      hresp <= 1'b0;
    end
  end

  wire wr_duty_lo = wr_pend_ff & (wr_addr_ff == `DUTY_LOW_OFS);
  wire wr_duty_hi = wr_pend_ff & (wr_addr_ff == `DUTY_HIGH_OFS);
  wire wr_per_lo = wr_pend_ff & (wr_addr_ff == `PERIOD_LOW_OFS);
  wire wr_per_hi = wr_pend_ff & (wr_addr_ff == `PERIOD_HIGH_OFS);
  wire wr_lctrl = wr_pend_ff & (wr_addr_ff == `LOWER_CTRL_OFS);
  wire wr_uctrl = wr_pend_ff & (wr_addr_ff == `UPPER_CTRL_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  reg [7:0] lower_timer_control_ff;
  reg [7:0] upper_timer_control_ff;
  wire [2:0] mode;
  wire [2:0] clk_sel;
  wire prescaler_halve_select;
  wire start_now;
  wire start_new;
  wire pwm_mode;
  wire ppg_mode;
  wire running;

  assign mode = upper_timer_control_ff[`UCTRL_MODE_HI:`UCTRL_MODE_LO];
  assign clk_sel = lower_timer_control_ff[`LCTRL_CLK_HI:`LCTRL_CLK_LO];
  assign prescaler_halve_select = lower_timer_control_ff[`LCTRL_HALVE_BIT];
  assign start_now = upper_timer_control_ff[`UCTRL_START_BIT];
  assign start_new = wr_byte[`UCTRL_START_BIT];
  assign pwm_mode = (mode == `MODE_PWM16);
  assign ppg_mode = (mode == `MODE_PPG16);
  assign running = start_now & (pwm_mode | ppg_mode);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lower_timer_control_ff <= `CTRL_RESET;
      upper_timer_control_ff <= `CTRL_RESET;
    end else begin
      if (wr_lctrl) begin
        lower_timer_control_ff <= wr_byte;
      end
      if (wr_uctrl) begin
        upper_timer_control_ff <= wr_byte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count source

  reg [`PRESC_WIDTH-1:0] presc_ff;
  reg ext_prev_ff;
  reg [3:0] tap_exp;
  wire [`PRESC_WIDTH-1:0] tap_mask;
  wire presc_tick;
  wire ext_fall;
  wire count_tick;

  // Halving the rate doubles every division ratio
  always @* begin
    case (clk_sel)
      `CLK_DIV2_11: tap_exp = `TAP_EXP_11; // R21
      `CLK_DIV2_7: tap_exp = `TAP_EXP_7;
      `CLK_DIV2_5: tap_exp = `TAP_EXP_5;
      `CLK_DIV2_3: tap_exp = `TAP_EXP_3;
      default: tap_exp = `TAP_EXP_3;
    endcase
    tap_exp = tap_exp + {3'h0, prescaler_halve_select}; // R21
  end

  assign tap_mask = ~({`PRESC_WIDTH{1'b1}} << tap_exp);
  assign presc_tick = ((presc_ff & tap_mask) == tap_mask);
  // Falling edges only; the source keeps each level two cycles or more
  assign ext_fall = ext_prev_ff & ~external_count_input; // R05
  assign count_tick = (clk_sel == `CLK_EXTERNAL) ? ext_fall : presc_tick; // R02

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      presc_ff <= {`PRESC_WIDTH{1'b0}};
      ext_prev_ff <= 1'b1;
    end else begin
      presc_ff <= presc_ff + {{(`PRESC_WIDTH-1){1'b0}}, 1'b1};
      ext_prev_ff <= external_count_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compare registers

  reg [7:0] duty_temp_ff;
  reg [7:0] period_temp_ff;
  reg [15:0] duty_pending_ff;
  reg [15:0] duty_active_ff;
  reg [15:0] period_active_ff;
  reg duty_waiting_ff;
  wire [15:0] duty_written;
  wire period_hit;

  assign duty_written = {wr_byte, duty_temp_ff}; // R20

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      duty_temp_ff <= 8'h00;
      period_temp_ff <= 8'h00;
      duty_pending_ff <= `CMP_RESET;
      duty_active_ff <= `CMP_RESET;
      period_active_ff <= `CMP_RESET;
      duty_waiting_ff <= 1'b0;
    end else begin
      if (wr_duty_lo) begin
        duty_temp_ff <= wr_byte; // R20
      end
      if (wr_per_lo) begin
        period_temp_ff <= wr_byte; // R20
      end
      if (wr_per_hi) begin
        period_active_ff <= {wr_byte, period_temp_ff}; // R18
      end
      // A write landing with the interrupt stays pending for the next one
      if (period_hit && duty_waiting_ff) begin
        duty_active_ff <= duty_pending_ff; // R08
        duty_waiting_ff <= 1'b0;
      end
      if (wr_duty_hi) begin
        if (running && pwm_mode) begin
          duty_pending_ff <= duty_written; // R08
          duty_waiting_ff <= 1'b1;
        end else begin
          duty_active_ff <= duty_written; // R09 R18
          duty_pending_ff <= duty_written;
          duty_waiting_ff <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascaded counter and output flip-flop

  reg [7:0] cnt_lo_ff;
  reg [7:0] cnt_hi_ff;
  reg output_toggle_flipflop;
  wire [15:0] cnt;
  wire duty_hit;
  wire end_hit;
  reg nxt_toggle;
  reg nxt_level;

  assign cnt = {cnt_hi_ff, cnt_lo_ff}; // R01
  assign duty_hit = running & count_tick & (cnt == duty_active_ff); // R03
  assign end_hit = pwm_mode ? (cnt == `CNT_MAX) : // R04
                   (cnt == period_active_ff); // R17
  assign period_hit = running & count_tick & end_hit;

  // Both edges on one tick cancel out
  always @* begin
    nxt_toggle = duty_hit ^ period_hit; // R03 R04 R17
    nxt_level = output_toggle_flipflop ^ nxt_toggle;
    if (wr_uctrl && !(start_now && !start_new)) begin
      // Load while stopped or on a write keeping bit 3 set; a stopping write holds the level
      nxt_level = wr_byte[`UCTRL_LEVEL_BIT]; // R06 R13 R15
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_lo_ff <= 8'h00;
      cnt_hi_ff <= 8'h00;
      output_toggle_flipflop <= 1'b0; // R06
    end else begin
      output_toggle_flipflop <= nxt_level;
      if (wr_uctrl && start_new && !start_now) begin
        cnt_lo_ff <= 8'h00; // R22
        cnt_hi_ff <= 8'h00;
      end else if (period_hit) begin
        cnt_lo_ff <= 8'h00; // R04 R17
        cnt_hi_ff <= 8'h00;
      end else if (running && count_tick) begin
        cnt_lo_ff <= cnt_lo_ff + 8'h01; // R01
        if (cnt_lo_ff == 8'hFF) begin
          cnt_hi_ff <= cnt_hi_ff + 8'h01; // R01
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins and interrupt

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      inverted_pwm_pin <= 1'b1;
      inverted_ppg_pin <= 1'b1;
      period_irq <= 1'b0;
    end else begin
      inverted_pwm_pin <= ~nxt_level; // R07 R15
      inverted_ppg_pin <= ~nxt_level; // R07
      period_irq <= period_hit; // R04 R17
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  reg rd_pend_ff;
  reg [7:0] rd_addr_ff;
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h0000_0000;
    case (rd_addr_ff)
      `DUTY_LOW_OFS: rd_word[7:0] = duty_active_ff[7:0]; // R10
      `DUTY_HIGH_OFS: rd_word[7:0] = duty_active_ff[15:8]; // R10
      `PERIOD_LOW_OFS: rd_word[7:0] = period_active_ff[7:0];
      `PERIOD_HIGH_OFS: rd_word[7:0] = period_active_ff[15:8];
      `LOWER_CTRL_OFS: rd_word[7:0] = lower_timer_control_ff;
      `UPPER_CTRL_OFS: rd_word[7:0] = upper_timer_control_ff;
      `STATUS_OFS: begin
        rd_word[`STAT_CNT_LO+15:`STAT_CNT_LO] = cnt;
        rd_word[`STAT_FF_BIT] = output_toggle_flipflop;
        rd_word[`STAT_RUN_BIT] = running;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      rd_pend_ff <= rd_take;
      if (rd_take) begin
        rd_addr_ff <= haddr;
      end
      if (rd_pend_ff) begin
        hrdata <= rd_word;
      end
    end
  end

endmodule // pwm_ppg_timer

// file: testbench/pwm_ppg_timer_checker.sv
// Bus and pin assertions for the 16-bit pulse timer
module pwm_ppg_timer_checker (
  // Clock and reset
  input wire sys_clk,
  input wire resetn,
  // Bus
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  // Pins
  input wire external_count_input,
  input wire inverted_pwm_pin,
  input wire inverted_ppg_pin,
  input wire period_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  wire bus_take = hsel && hready && htrans[1];
  chk_pins_match: assert property (inverted_pwm_pin == inverted_ppg_pin)
    else $error("pins differ");
  chk_irq_single: assert property (period_irq |=> !period_irq)
    else $error("irq too long");
  chk_irq_flip: assert property (period_irq |->
    inverted_pwm_pin != $past(inverted_pwm_pin))
    else $error("no toggle at irq");
  chk_bus_okay: assert property (!hresp)
    else $error("bad response");
  chk_read_wait: assert property (bus_take && !hwrite |=>
    !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  chk_write_nowait: assert property (bus_take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_unmapped_zero: assert property (bus_take && !hwrite &&
    haddr == 8'h1C |=> ##1 hrdata == 32'h0000_0000)
    else $error("unmapped data");
  chk_rdata_hold: assert property (hreadyout && $past(hreadyout) |->
    $stable(hrdata))
    else $error("read data moved");
endmodule // pwm_ppg_timer_checker

bind pwm_ppg_timer pwm_ppg_timer_checker chk_i (.*);

// file: testbench/pulse_load_model.sv
// Count source and pin load beside the pulse timer
module pulse_load_model (
  // Clock and pins
  input wire logic sys_clk,
  input wire logic inverted_pwm_pin,
  output logic external_count_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_ff;
  initial phase_ff = 2'h0;
  initial external_count_input = 1'b1;
  // Pin is taken as already enabled for pulse output by the port latch
  // Three cycles per level, above the two-cycle minimum
  always @(posedge sys_clk) begin
    phase_ff <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
    if (phase_ff == 2'h2)
      external_count_input <= ~external_count_input;
  end
endmodule // pulse_load_model

// file: testbench/pwm_ppg_timer_bench.sv
// Self-checking bench for the 16-bit pulse timer
module pwm_ppg_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, hsel, hwrite, pin_q, irq_pin;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, q;
  logic [15:0] d, n, p;
  wire hready, hreadyout, hresp, external_count_input;
  wire inverted_pwm_pin, inverted_ppg_pin, period_irq;
  wire [31:0] hrdata;
  int num_errors, checks_done, cyc, irq_last, irq_gap, fall_gap, irq_cnt, w;
  assign hready = hreadyout;
  pwm_ppg_timer dut (.*);
  pulse_load_model load_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    pin_q <= inverted_pwm_pin;
    if (period_irq) begin
      irq_gap <= cyc - irq_last;
      irq_last <= cyc;
      irq_cnt <= irq_cnt + 1;
      irq_pin <= inverted_pwm_pin;
    end
    if (pin_q && !inverted_pwm_pin)
      fall_gap <= cyc - irq_last;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end
  ////////////////////////////////////////
  // Called just after a rising edge; hready and hrdata read pre-update
  task automatic wait_ready();
    do begin
      @(posedge sys_clk);
    end while (hready !== 1'b1);
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, v);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    htrans <= 2'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, v};
    wait_ready();
    q = hrdata;
  endtask
  task automatic check(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic int span(input int ticks, input int div);
    return div * (ticks + 1);
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    q = $urandom(32'h0000_bef5);
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 8'(i * 4), 8'h00);
      check(q, 32'h0000_0000);
    end
    check({31'h0, inverted_pwm_pin}, 32'h0000_0001);
    $display("reset test done");
    d = 16'($urandom_range(20, 4));
    bus(1'b1, 8'h00, d[7:0]);
    bus(1'b0, 8'h00, 8'h00);
    check(q, 32'h0000_0000);
    bus(1'b1, 8'h04, d[15:8]);
    bus(1'b0, 8'h00, 8'h00);
    check(q, {24'h00_0000, d[7:0]});
    // New duty written early in the run must not move this toggle
    n = 16'($urandom_range(90, 40));
    bus(1'b1, 8'h10, 8'h30);
    bus(1'b1, 8'h14, 8'h0E);
    // Written far from the overflow, never on the interrupt cycle
    bus(1'b1, 8'h00, n[7:0]);
    bus(1'b1, 8'h04, n[15:8]);
    bus(1'b0, 8'h00, 8'h00);
    check(q, {24'h00_0000, d[7:0]});
    while (inverted_pwm_pin !== 1'b0) @(posedge sys_clk);
    bus(1'b0, 8'h18, 8'h00);
    check(q, {16'h0003, d + 16'h0001});
    $display("pwm test done");
    bus(1'b1, 8'h14, 8'h06);
    repeat (40) @(posedge sys_clk);
    bus(1'b0, 8'h18, 8'h00);
    check(q, {16'h0001, d + 16'h0001});
    bus(1'b1, 8'h14, 8'h06);
    repeat (3) @(posedge sys_clk);
    check({31'h0, inverted_pwm_pin}, 32'h0000_0001);
    bus(1'b1, 8'h14, 8'h86);
    repeat (3) @(posedge sys_clk);
    check({31'h0, inverted_pwm_pin}, 32'h0000_0000);
    $display("stop test done");
    for (int k = 0; k < 2; k++) begin
      p = 16'($urandom_range(24, 6));
      n = 16'($urandom_range(p - 1, 1));
      bus(1'b1, 8'h14, 8'h07);
      bus(1'b1, 8'h10, k ? 8'h70 : 8'h30);
      bus(1'b1, 8'h00, n[7:0]);
      bus(1'b1, 8'h04, n[15:8]);
      bus(1'b1, 8'h08, p[7:0]);
      bus(1'b1, 8'h0C, p[15:8]);
      bus(1'b1, 8'h14, 8'h0F);
      w = irq_cnt + 2;
      while (irq_cnt < w) @(posedge sys_clk);
      check(irq_gap, span(p, k ? 6 : 8));
      check(fall_gap, span(n, k ? 6 : 8));
      check({31'h0, irq_pin}, 32'h0000_0001);
      $display("ppg test %0d done", k);
    end
    final_report();
  end
endmodule // pwm_ppg_timer_bench
